// >>> verilog/ppo_pkg.sv
// Behaviour
// (R01) timer0 compare-A drives port D bit 6 when enabled and direction bit set
// (R02) timer0 compare-B drives port D bit 5 when enabled and direction bit set
// (R03) timer2 compare-B drives port D bit 3 when enabled and direction bit set
// (R04) transmitter enable forces port D bit 1 output, transmit data, pull-up off
// (R05) receiver enable forces port D bit 0 input, synchronized value to receiver
// (R06) receiver-owned bit 0 pull-up follows output bit, gated by pull-up disable
// (R07) bit 4 carries external clock; mode select drives it; input feeds clock, timer0
// (R08) port D bits are pin-change sources 16..23; mask and group force input buffer
// (R09) bit 3 feeds ext irq one, bit 2 ext irq zero; enable forces input buffer
// (R10) bit 5 feeds timer1 count input, bit 4 timer0 count input, no override
// (R11) software sets comparator pins 7 and 6 as inputs with pull-ups off
// (R12) global pull-up disable turns off every port pull-up
// (R13) input-pins registers are read-only sampled levels; reserved bits read zero
// (R14) port B output and direction read-write, reset zero, pins start as inputs
// (R15) port C bit 7 reserved, read-only zero in all three registers
// (R16) control register reserved bits zero, brown-out bits read-only, all reset zero
// (R17) reset-pin function on port C bit 6 reads zero in all three registers
// (R18) each asserted override enable replaces the register-derived pin control
// (R19) each register answers at its address and at the address 0x20 higher
package ppo_pkg;

	// ----------------------------------------------------------------
	// register offsets (word index; byte address is four times it)
	// ----------------------------------------------------------------
	localparam logic [7:0] PPO_PORT_B_INPUT_PINS = 8'h03;
	localparam logic [7:0] PPO_PORT_B_DIRECTION = 8'h04;
	localparam logic [7:0] PPO_PORT_B_OUTPUT = 8'h05;
	localparam logic [7:0] PPO_PORT_C_INPUT_PINS = 8'h06;
	localparam logic [7:0] PPO_PORT_C_DIRECTION = 8'h07;
	localparam logic [7:0] PPO_PORT_C_OUTPUT = 8'h08;
	localparam logic [7:0] PPO_MICRO_CONTROL = 8'h35;
	localparam logic [7:0] PPO_DATA_SPACE_OFS = 8'h20;
	localparam logic [7:0] PPO_PORT_D_OVR_CTRL = 8'h40;

	// ----------------------------------------------------------------
	// field positions and masks
	// ----------------------------------------------------------------
	localparam int PPO_MC_PUD_BIT = 4;
	localparam logic [7:0] PPO_MC_WR_MASK = 8'h13;
	localparam logic [7:0] PPO_PORT_C_MASK = 8'h7F;
	localparam int PPO_PC_RESET_BIT = 6;
	localparam int PPO_PD_RXD = 0;
	localparam int PPO_PD_TXD = 1;
	localparam int PPO_PD_EXT_IRQ_ZERO_INPUT = 2;
	localparam int PPO_PD_EXT_IRQ_ONE_INPUT = 3;
	localparam int PPO_PD_XCK = 4;
	localparam int PPO_PD_TIMER0_COMPARE_B_OUT = 5;
	localparam int PPO_PD_TIMER0_COMPARE_A_OUT = 6;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] PPO_RESET_ZERO = 8'h00;

endpackage

// >>> verilog/ppo_pin_sync.sv
`timescale 1ns/10ps
// two-stage synchroniser for a bus of pin levels
module ppo_pin_sync #(
	parameter int WIDTH = 8
) (
	input wire logic clock, // system clock
	input wire logic rst_b, // sync reset, active low
	input wire logic clk_en, // freeze when low
	input wire logic [WIDTH-1:0] async_in, // raw pin levels
	output logic [WIDTH-1:0] sync_out // synchronised levels
);
	logic [WIDTH-1:0] meta_r;

	// first stage read only by the second
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			meta_r <= '0;
			sync_out <= '0;
		end else if (clk_en) begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule

// >>> verilog/ppo_port_pin_override_logic.sv
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/10ps
module ppo_port_pin_override_logic
	import ppo_pkg::*;
(
	input wire logic clock, // system clock
	input wire logic rst_b, // sync reset, active low
	input wire logic clk_en, // freezes all state when low
	// avalon-mm slave
	input wire logic [9:0] avs_address, // byte address
	input wire logic avs_read, // read request
	input wire logic avs_write, // write request
	input wire logic [31:0] avs_writedata, // write data
	input wire logic [3:0] avs_byteenable, // byte lanes
	output logic [31:0] avs_readdata, // read data
	output logic avs_waitrequest, // stall
	output logic avs_response_err, // unmapped access
	// port b and c pins
	input wire logic [7:0] port_b_pin_in, // port b pad levels
	output logic [7:0] port_b_pin_out, // port b drive value
	output logic [7:0] port_b_pin_oe, // port b drive enable
	output logic [7:0] port_b_pullup, // port b pull-up on
	input wire logic [6:0] port_c_pin_in, // port c pad levels
	output logic [6:0] port_c_pin_out, // port c drive value
	output logic [6:0] port_c_pin_oe, // port c drive enable
	output logic [6:0] port_c_pullup, // port c pull-up on
	input wire logic reset_pin_function, // port c bit 6 is reset pin
	// port d pins
	input wire logic [7:0] port_d_pin_in, // port d pad levels
	input wire logic [7:0] port_d_direction, // port d direction bits
	input wire logic [7:0] port_d_output, // port d output bits
	output logic [7:0] port_d_pin_out, // port d drive value
	output logic [7:0] port_d_pin_oe, // port d drive enable
	output logic [7:0] port_d_pullup, // port d pull-up on
	output logic [7:0] port_d_input_buf_en, // digital input buffer on
	// peripherals
	input wire logic timer0_compare_a_out, // compare-a waveform
	input wire logic timer0_compare_a_en, // compare-a enable
	input wire logic timer0_compare_b_out, // compare-b waveform
	input wire logic timer0_compare_b_en, // compare-b enable
	input wire logic timer2_compare_b_out, // timer2 compare-b waveform
	input wire logic timer2_compare_b_en, // timer2 compare-b enable
	input wire logic transmitter_enable, // usart tx enable
	input wire logic transmit_data, // usart serial out
	input wire logic receiver_enable, // usart rx enable
	input wire logic serial_mode_select, // usart sync mode
	input wire logic serial_ext_clock_gen, // generated usart clock
	input wire logic [7:0] pin_change_source, // pin-change masks 16..23
	input wire logic pin_change_group1_enable, // group 1 enable
	input wire logic pin_change_group2_enable, // group 2 enable
	input wire logic ext_irq_zero_enable, // ext irq 0 enabled
	input wire logic ext_irq_one_enable, // ext irq 1 enabled
	output logic receive_data, // rx input to usart
	output logic serial_ext_clock, // usart clock input
	output logic timer0_count_input, // timer0 count input
	output logic timer1_count_input, // timer1 count input
	output logic ext_irq_zero_input, // ext irq 0 input
	output logic ext_irq_one_input, // ext irq 1 input
	output logic [7:0] port_d_pin_level // synchronised port d levels
);
	// ----------------------------------------------------------------
	// registers and synchronisers
	// ----------------------------------------------------------------
	logic [7:0] b_dir_r, b_out_r, c_dir_r, c_out_r, mc_r;
	logic [7:0] b_sync, c_sync_raw, d_sync;
	logic [7:0] c_pins_in;
	logic [7:0] b_in_r, c_in_r;
	logic ack_r;
	logic global_pullup_disable;

	assign c_pins_in = {1'b0, port_c_pin_in};
	assign global_pullup_disable = mc_r[PPO_MC_PUD_BIT];

	// pad levels are asynchronous, so all pass two flops
	ppo_pin_sync #(.WIDTH(8)) u_sync_b (
		.clock(clock), .rst_b(rst_b), .clk_en(clk_en),
		.async_in(port_b_pin_in), .sync_out(b_sync));
	ppo_pin_sync #(.WIDTH(8)) u_sync_c (
		.clock(clock), .rst_b(rst_b), .clk_en(clk_en),
		.async_in(c_pins_in), .sync_out(c_sync_raw));
	ppo_pin_sync #(.WIDTH(8)) u_sync_d (
		.clock(clock), .rst_b(rst_b), .clk_en(clk_en),
		.async_in(port_d_pin_in), .sync_out(d_sync));

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	// fold the data-space alias onto the io offset
	function automatic logic [7:0] reg_index(input logic [9:0] addr);
		logic [7:0] idx;
		idx = addr[9:2];
		// fold only when the io index itself is free, so 0x35 is never moved
		if (!is_mapped(idx) && is_mapped(idx - PPO_DATA_SPACE_OFS) &&
			idx != PPO_PORT_D_OVR_CTRL)
			idx = idx - PPO_DATA_SPACE_OFS; // R19
		return idx;
	endfunction

	function automatic logic is_mapped(input logic [7:0] idx);
		return idx == PPO_PORT_B_INPUT_PINS || idx == PPO_PORT_B_DIRECTION ||
			idx == PPO_PORT_B_OUTPUT || idx == PPO_PORT_C_INPUT_PINS ||
			idx == PPO_PORT_C_DIRECTION || idx == PPO_PORT_C_OUTPUT ||
			idx == PPO_MICRO_CONTROL;
	endfunction

	logic [7:0] idx;
	logic req, wr_ok;
	assign idx = reg_index(avs_address);
	assign req = (avs_read || avs_write) && !ack_r;
	// write lands only on the edge where the master sees waitrequest low
	assign wr_ok = ack_r && avs_write && avs_byteenable[0] && clk_en;

	// one wait cycle: request is taken on the edge where waitrequest is low
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			ack_r <= 1'b0;
			avs_waitrequest <= 1'b1;
		end else if (clk_en) begin
			ack_r <= req;
			avs_waitrequest <= !req;
		end
	end

	// port b registers, reset to inputs with no pull-up
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			b_dir_r <= PPO_RESET_ZERO; // R14
			b_out_r <= PPO_RESET_ZERO; // R14
		end else if (wr_ok && idx == PPO_PORT_B_DIRECTION) begin
			b_dir_r <= avs_writedata[7:0];
		end else if (wr_ok && idx == PPO_PORT_B_OUTPUT) begin
			b_out_r <= avs_writedata[7:0];
		end
	end

	// port c registers; reserved bit 7 never stored
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			c_dir_r <= PPO_RESET_ZERO;
			c_out_r <= PPO_RESET_ZERO;
		end else if (wr_ok && idx == PPO_PORT_C_DIRECTION) begin
			c_dir_r <= avs_writedata[7:0] & PPO_PORT_C_MASK; // R15
		end else if (wr_ok && idx == PPO_PORT_C_OUTPUT) begin
			c_out_r <= avs_writedata[7:0] & PPO_PORT_C_MASK; // R15
		end
	end

	// control register: only pull-up disable and vector bits are writable
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			mc_r <= PPO_RESET_ZERO; // R16
		end else if (wr_ok && idx == PPO_MICRO_CONTROL) begin
			mc_r <= avs_writedata[7:0] & PPO_MC_WR_MASK; // R16
		end
	end

	// sampled pin levels, reserved and reset-pin bits forced to zero
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			b_in_r <= PPO_RESET_ZERO;
			c_in_r <= PPO_RESET_ZERO;
		end else if (clk_en) begin
			b_in_r <= b_sync; // R13
			c_in_r <= c_sync_raw & PPO_PORT_C_MASK; // R13
			if (reset_pin_function)
				c_in_r[PPO_PC_RESET_BIT] <= 1'b0; // R17
		end
	end

	// read mux; reset pin hides port c bit 6 from software
	logic [7:0] rd_val, c_dir_vis, c_out_vis;
	always_comb begin
		c_dir_vis = c_dir_r;
		c_out_vis = c_out_r;
		if (reset_pin_function) begin
			c_dir_vis[PPO_PC_RESET_BIT] = 1'b0; // R17
			c_out_vis[PPO_PC_RESET_BIT] = 1'b0; // R17
		end
		case (idx)
			PPO_PORT_B_INPUT_PINS: rd_val = b_in_r;
			PPO_PORT_B_DIRECTION: rd_val = b_dir_r;
			PPO_PORT_B_OUTPUT: rd_val = b_out_r;
			PPO_PORT_C_INPUT_PINS: rd_val = c_in_r;
			PPO_PORT_C_DIRECTION: rd_val = c_dir_vis;
			PPO_PORT_C_OUTPUT: rd_val = c_out_vis;
			PPO_MICRO_CONTROL: rd_val = mc_r;
			default: rd_val = PPO_RESET_ZERO;
		endcase
	end

	// read data and error registered with the answer
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			avs_readdata <= '0;
			avs_response_err <= 1'b0;
		end else if (clk_en) begin
			avs_readdata <= (req && avs_read) ? {24'h000000, rd_val} : '0;
			avs_response_err <= req && !is_mapped(idx);
		end
	end

	// ----------------------------------------------------------------
	// port b and c pin control
	// ----------------------------------------------------------------
	// pull-up only for input with output bit set and no global disable
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			port_b_pin_out <= '0;
			port_b_pin_oe <= '0;
			port_b_pullup <= '0;
			port_c_pin_out <= '0;
			port_c_pin_oe <= '0;
			port_c_pullup <= '0;
		end else if (clk_en) begin
			port_b_pin_out <= b_out_r;
			port_b_pin_oe <= b_dir_r;
			port_b_pullup <= ~b_dir_r & b_out_r & {8{~global_pullup_disable}}; // R12
			port_c_pin_out <= c_out_r[6:0];
			port_c_pin_oe <= c_dir_r[6:0];
			port_c_pullup <= ~c_dir_r[6:0] & c_out_r[6:0] & {7{~global_pullup_disable}}; // R12
		end
	end

	// ----------------------------------------------------------------
	// port d override network
	// ----------------------------------------------------------------
	logic [7:0] pullup_override_enable, pullup_override_value, direction_override_enable, direction_override_value, output_value_override_enable, output_value_override_value, input_buffer_override_enable;
	logic [7:0] d_dir, d_val, d_pu, d_die;
	always_comb begin
		pullup_override_enable = '0;
		pullup_override_value = '0;
		direction_override_enable = '0;
		direction_override_value = '0;
		output_value_override_enable = '0;
		output_value_override_value = '0;
		// comparator pins 7/6 need no override: software keeps them inputs
		output_value_override_enable[PPO_PD_TIMER0_COMPARE_A_OUT] = timer0_compare_a_en; // R01
		output_value_override_value[PPO_PD_TIMER0_COMPARE_A_OUT] = timer0_compare_a_out; // R01
		output_value_override_enable[PPO_PD_TIMER0_COMPARE_B_OUT] = timer0_compare_b_en; // R02
		output_value_override_value[PPO_PD_TIMER0_COMPARE_B_OUT] = timer0_compare_b_out; // R02
		output_value_override_enable[PPO_PD_EXT_IRQ_ONE_INPUT] = timer2_compare_b_en; // R03
		output_value_override_value[PPO_PD_EXT_IRQ_ONE_INPUT] = timer2_compare_b_out; // R03
		output_value_override_enable[PPO_PD_XCK] = serial_mode_select; // R07
		output_value_override_value[PPO_PD_XCK] = serial_ext_clock_gen; // R07
		pullup_override_enable[PPO_PD_TXD] = transmitter_enable; // R04
		direction_override_enable[PPO_PD_TXD] = transmitter_enable; // R04
		direction_override_value[PPO_PD_TXD] = 1'b1; // R04
		output_value_override_enable[PPO_PD_TXD] = transmitter_enable; // R04
		output_value_override_value[PPO_PD_TXD] = transmit_data; // R04
		pullup_override_enable[PPO_PD_RXD] = receiver_enable; // R05
		direction_override_enable[PPO_PD_RXD] = receiver_enable; // R05
		pullup_override_value[PPO_PD_RXD] = port_d_output[PPO_PD_RXD] & ~global_pullup_disable; // R06
		// source 18 sits in group 1 as printed
		input_buffer_override_enable = pin_change_source & {{5{pin_change_group2_enable}},
			pin_change_group1_enable, {2{pin_change_group2_enable}}}; // R08
		input_buffer_override_enable[PPO_PD_EXT_IRQ_ZERO_INPUT] = input_buffer_override_enable[PPO_PD_EXT_IRQ_ZERO_INPUT] | ext_irq_zero_enable; // R09
		input_buffer_override_enable[PPO_PD_EXT_IRQ_ONE_INPUT] = input_buffer_override_enable[PPO_PD_EXT_IRQ_ONE_INPUT] | ext_irq_one_enable; // R09
		// every override enable picks its value over the register path
		d_dir = (direction_override_enable & direction_override_value) | (~direction_override_enable & port_d_direction); // R18
		d_val = (output_value_override_enable & output_value_override_value) | (~output_value_override_enable & port_d_output); // R18
		d_pu = (pullup_override_enable & pullup_override_value) |
			(~pullup_override_enable & ~port_d_direction & port_d_output & {8{~global_pullup_disable}}); // R18 R12
		d_die = input_buffer_override_enable; // R18
	end

	// port d pad drive; compare outputs only leave when direction is one
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			port_d_pin_out <= '0;
			port_d_pin_oe <= '0;
			port_d_pullup <= '0;
			port_d_input_buf_en <= '0;
		end else if (clk_en) begin
			port_d_pin_out <= d_val;
			port_d_pin_oe <= d_dir; // R01 R02 R03
			port_d_pullup <= d_pu;
			port_d_input_buf_en <= d_die;
		end
	end

	// peripheral inputs come from the synchronised digital path
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			receive_data <= 1'b0;
			serial_ext_clock <= 1'b0;
			timer0_count_input <= 1'b0;
			timer1_count_input <= 1'b0;
			ext_irq_zero_input <= 1'b0;
			ext_irq_one_input <= 1'b0;
			port_d_pin_level <= '0;
		end else if (clk_en) begin
			receive_data <= d_sync[PPO_PD_RXD]; // R05
			serial_ext_clock <= d_sync[PPO_PD_XCK]; // R07
			timer0_count_input <= d_sync[PPO_PD_XCK]; // R10
			timer1_count_input <= d_sync[PPO_PD_TIMER0_COMPARE_B_OUT]; // R10
			ext_irq_zero_input <= d_sync[PPO_PD_EXT_IRQ_ZERO_INPUT]; // R09
			ext_irq_one_input <= d_sync[PPO_PD_EXT_IRQ_ONE_INPUT]; // R09
			port_d_pin_level <= d_sync; // R08
		end
	end
endmodule

// >>> tb/ppo_board_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// board side of one port: pads seen by the block
// ----------------------------------------
module ppo_board_model #(
	parameter int W = 8
) (
	input wire logic [W-1:0] drive, // block drive value
	input wire logic [W-1:0] oe, // block drive enable
	input wire logic [W-1:0] pull_on, // block pull-up on
	input wire logic [W-1:0] ext, // weak board bias on floating pads
	output logic [W-1:0] pad // resolved pad level
);
	// a driven pad wins; a pull-up beats the weak bias, so a wrong pull-up shows
	assign pad = (oe & drive) | (~oe & pull_on) | (~oe & ~pull_on & ext);
endmodule

// >>> tb/ppo_checker_sva.sv
`timescale 1ns/10ps
module ppo_checker (
	input wire logic clock, // system clock
	input wire logic rst_b, // sync reset, active low
	input wire logic clk_en, // run enable
	input wire logic avs_read, // read request
	input wire logic avs_write, // write request
	input wire logic avs_waitrequest, // stall
	input wire logic [7:0] port_b_pin_oe, // port b drive enable
	input wire logic [7:0] port_b_pullup, // port b pull-up
	input wire logic [6:0] port_c_pin_oe, // port c drive enable
	input wire logic [6:0] port_c_pullup, // port c pull-up
	input wire logic [7:0] port_d_pin_in, // port d pads
	input wire logic [7:0] port_d_direction, // port d direction bits
	input wire logic [7:0] port_d_output, // port d output bits
	input wire logic [7:0] port_d_pin_out, // port d drive value
	input wire logic [7:0] port_d_pin_oe, // port d drive enable
	input wire logic [7:0] port_d_pullup, // port d pull-up
	input wire logic [7:0] port_d_input_buf_en, // input buffer on
	input wire logic [7:0] port_d_pin_level, // synchronised levels
	input wire logic timer0_compare_a_out, // compare-a waveform
	input wire logic timer0_compare_a_en, // compare-a enable
	input wire logic timer0_compare_b_out, // compare-b waveform
	input wire logic timer0_compare_b_en, // compare-b enable
	input wire logic timer2_compare_b_out, // timer2 waveform
	input wire logic timer2_compare_b_en, // timer2 enable
	input wire logic transmitter_enable, // tx enable
	input wire logic transmit_data, // tx data
	input wire logic receiver_enable, // rx enable
	input wire logic serial_mode_select, // sync mode
	input wire logic serial_ext_clock_gen, // generated clock
	input wire logic [7:0] pin_change_source, // pin-change masks
	input wire logic pin_change_group1_enable, // group 1
	input wire logic pin_change_group2_enable, // group 2
	input wire logic ext_irq_zero_enable // ext irq 0 enable
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);
	// ----------------------------------------
	// run-time counter
	// ----------------------------------------
	// $past is only trusted once enough live edges have passed
	logic [1:0] up_r;
	always_ff @(posedge clock) begin
		if (!rst_b || !clk_en) up_r <= 2'h0;
		else if (up_r != 2'h3) up_r <= up_r + 2'h1;
	end
	sequence bus_req_s;
		clk_en && $rose(avs_read || avs_write);
	endsequence
	sequence ack_s;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence
	cmp_a_drive_a: assert property (up_r != 2'h0 && $past(timer0_compare_a_en) |->
		port_d_pin_out[6] == $past(timer0_compare_a_out) &&
		port_d_pin_oe[6] == $past(port_d_direction[6])) else $error("compare-a pin wrong");
	cmp_b_drive_a: assert property (up_r != 2'h0 && $past(timer0_compare_b_en) |->
		port_d_pin_out[5] == $past(timer0_compare_b_out) &&
		port_d_pin_oe[5] == $past(port_d_direction[5])) else $error("compare-b pin wrong");
	t2_drive_a: assert property (up_r != 2'h0 && $past(timer2_compare_b_en) |->
		port_d_pin_out[3] == $past(timer2_compare_b_out) &&
		port_d_pin_oe[3] == $past(port_d_direction[3])) else $error("timer2 pin wrong");
	tx_own_a: assert property (up_r != 2'h0 && $past(transmitter_enable) |->
		port_d_pin_oe[1] && !port_d_pullup[1] && port_d_pin_out[1] == $past(transmit_data))
		else $error("tx pin wrong");
	rx_own_a: assert property (up_r != 2'h0 && $past(receiver_enable) |->
		!port_d_pin_oe[0] && (!port_d_pullup[0] || $past(port_d_output[0])))
		else $error("rx pin wrong");
	xck_drive_a: assert property (up_r != 2'h0 && $past(serial_mode_select) |->
		port_d_pin_out[4] == $past(serial_ext_clock_gen)) else $error("clock pin wrong");
	buf_force_a: assert property (up_r != 2'h0 |->
		port_d_input_buf_en[7] == $past(pin_change_source[7] & pin_change_group2_enable) &&
		port_d_input_buf_en[2] == $past(ext_irq_zero_enable |
		(pin_change_source[2] & pin_change_group1_enable))) else $error("input buffer wrong");
	sync_lag_a: assert property (up_r == 2'h3 |->
		port_d_pin_level == $past(port_d_pin_in, 3)) else $error("pin level lag wrong");
	bus_answer_a: assert property (bus_req_s |=> ack_s) else $error("bus answer wrong");
	pull_dir_a: assert property ((port_b_pullup & port_b_pin_oe) == 8'h00 &&
		(port_c_pullup & port_c_pin_oe) == 7'h00) else $error("pull-up on output");
endmodule
bind ppo_port_pin_override_logic ppo_checker ppo_checker_inst (.*);

// >>> tb/testbench.sv
`timescale 1ns/10ps
module testbench;
	import ppo_pkg::*;
	logic clock = 1'b0, rst_b = 1'b0, clk_en = 1'b1, avs_read, avs_write, avs_waitrequest;
	logic [9:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0] avs_byteenable = 4'h1;
	logic avs_response_err, reset_pin_function, receive_data, serial_ext_clock;
	logic timer0_count_input, timer1_count_input, ext_irq_zero_input, ext_irq_one_input;
	logic [7:0] port_b_pin_in, port_b_pin_out, port_b_pin_oe, port_b_pullup, b_ext;
	logic [6:0] port_c_pin_in, port_c_pin_out, port_c_pin_oe, port_c_pullup, c_ext;
	logic [7:0] port_d_pin_in, port_d_direction, port_d_output, port_d_pin_out, port_d_pin_oe;
	logic [7:0] port_d_pullup, port_d_input_buf_en, port_d_pin_level, pin_change_source, d_ext;
	logic timer0_compare_a_out, timer0_compare_a_en, timer0_compare_b_out, timer0_compare_b_en;
	logic timer2_compare_b_out, timer2_compare_b_en, transmitter_enable, transmit_data;
	logic receiver_enable, serial_mode_select, serial_ext_clock_gen, pin_change_group1_enable;
	logic pin_change_group2_enable, ext_irq_zero_enable, ext_irq_one_enable;
	logic [7:0] rd;
	logic er;
	int fail_count = 0, tests_run = 0;
	// ----------------------------------------
	// clock, design and board
	// ----------------------------------------
	always #5 clock = ~clock;
	ppo_port_pin_override_logic ppo_port_pin_override_logic_inst (.*);
	ppo_board_model #(.W(8)) board_b (.drive(port_b_pin_out), .oe(port_b_pin_oe),
		.pull_on(port_b_pullup), .ext(b_ext), .pad(port_b_pin_in));
	ppo_board_model #(.W(7)) board_c (.drive(port_c_pin_out), .oe(port_c_pin_oe),
		.pull_on(port_c_pullup), .ext(c_ext), .pad(port_c_pin_in));
	ppo_board_model #(.W(8)) board_d (.drive(port_d_pin_out), .oe(port_d_pin_oe),
		.pull_on(port_d_pullup), .ext(d_ext), .pad(port_d_pin_in));
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one transfer; the request holds until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
		int n;
		@(posedge clock);
		avs_address <= {idx, 2'h0};
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= {24'h000000, wd};
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 16);
		rd = avs_readdata[7:0];
		er = avs_response_err;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 16) begin
			fail_count++;
			wrap_up();
		end
	endtask
	task automatic rchk(input string nm, input logic [7:0] idx, input logic [7:0] e);
		bus(1'b0, idx, 8'h00);
		chk(nm, e, rd);
	endtask
	task automatic t_regs;
		logic [7:0] ix[5] = '{8'h04, 8'h05, 8'h07, 8'h08, 8'h35};
		foreach (ix[i]) rchk("reset value", ix[i], 8'h00);
		bus(1'b1, 8'h04, 8'hFF);
		bus(1'b1, 8'h25, 8'hA5);
		bus(1'b1, 8'h07, 8'hFF);
		bus(1'b1, 8'h28, 8'hFF);
		bus(1'b1, 8'h35, 8'hFF);
		rchk("b dir alias", 8'h24, 8'hFF);
		rchk("b out", 8'h05, 8'hA5);
		rchk("c dir", 8'h07, 8'h7F);
		rchk("c out", 8'h08, 8'h7F);
		rchk("control alias", 8'h55, 8'h13);
		bus(1'b1, 8'h35, 8'h00);
		bus(1'b0, 8'h40, 8'h00);
		chk("unmapped error", 8'h01, {7'h00, er});
		avs_byteenable <= 4'h0;
		bus(1'b1, 8'h04, 8'h00);
		avs_byteenable <= 4'h1;
		rchk("no lane write", 8'h04, 8'hFF);
		$display("t_regs done");
	endtask
	task automatic t_pins;
		bus(1'b1, 8'h04, 8'h0F);
		bus(1'b1, 8'h05, 8'h35);
		repeat (2) @(posedge clock);
		chk("b oe", 8'h0F, port_b_pin_oe);
		chk("b pullup", 8'h30, port_b_pullup);
		chk("b drive", 8'h05, port_b_pin_out & 8'h0F);
		chk("c drive", 8'h7F, {1'b0, port_c_pin_oe & port_c_pin_out & ~port_c_pullup});
		repeat (3) @(posedge clock);
		rchk("b input pins", 8'h03, 8'h35);
		bus(1'b1, 8'h35, 8'h10);
		repeat (2) @(posedge clock);
		chk("b pullup off", 8'h00, port_b_pullup);
		repeat (3) @(posedge clock);
		rchk("b input off", 8'h23, 8'h05);
		bus(1'b1, 8'h35, 8'h00);
		reset_pin_function <= 1'b1;
		rchk("c dir reset pin", 8'h07, 8'h3F);
		rchk("c in reset pin", 8'h06, 8'h3F);
		reset_pin_function <= 1'b0;
		rchk("c dir kept", 8'h07, 8'h7F);
		$display("t_pins done");
	endtask
	task automatic t_port_d;
		@(posedge clock);
		port_d_direction <= 8'h69;
		port_d_output <= 8'h01;
		{timer0_compare_a_en, timer0_compare_a_out, timer0_compare_b_en, timer0_compare_b_out,
			timer2_compare_b_en, timer2_compare_b_out, transmitter_enable, transmit_data,
			receiver_enable, serial_mode_select, serial_ext_clock_gen} <= 11'h7FF;
		pin_change_source <= 8'h84;
		{pin_change_group2_enable, ext_irq_one_enable} <= 2'h3;
		repeat (2) @(posedge clock);
		chk("d drive", 8'h6A, port_d_pin_out & port_d_pin_oe);
		chk("d oe", 8'h6A, port_d_pin_oe);
		chk("d pullup", 8'h01, port_d_pullup);
		chk("d buffer grp2", 8'h88, port_d_input_buf_en);
		{pin_change_group1_enable, pin_change_group2_enable} <= 2'h2;
		repeat (2) @(posedge clock);
		chk("d buffer grp1", 8'h0C, port_d_input_buf_en);
		{timer0_compare_a_en, timer0_compare_b_en, timer2_compare_b_en, transmitter_enable,
			receiver_enable, serial_mode_select, ext_irq_one_enable} <= 7'h00;
		port_d_direction <= 8'h3C;
		port_d_output <= 8'h25;
		repeat (2) @(posedge clock);
		chk("d plain drive", 8'h24, port_d_pin_out & port_d_pin_oe);
		chk("d plain oe", 8'h3C, port_d_pin_oe);
		repeat (4) @(posedge clock);
		chk("d level", 8'h25, port_d_pin_level);
		chk("timer1 count", 8'h01, {7'h00, timer1_count_input});
		chk("timer0 count", 8'h00, {7'h00, timer0_count_input});
		chk("d peripheral in", 8'h0A, {4'h0, receive_data, serial_ext_clock,
			ext_irq_zero_input, ext_irq_one_input});
		$display("t_port_d done");
	endtask
	initial begin
		{avs_read, avs_write, reset_pin_function, timer0_compare_a_out, timer0_compare_a_en,
			timer0_compare_b_out, timer0_compare_b_en, timer2_compare_b_out, timer2_compare_b_en,
			transmitter_enable, transmit_data, receiver_enable, serial_mode_select,
			serial_ext_clock_gen, pin_change_group1_enable, pin_change_group2_enable,
			ext_irq_zero_enable, ext_irq_one_enable} = 18'h00000;
		{avs_address, avs_writedata, port_d_direction, port_d_output, pin_change_source} = '0;
		{b_ext, c_ext, d_ext} = '0;
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		t_regs();
		t_pins();
		t_port_d();
		wrap_up();
	end
endmodule
